/* hw/hub_port_tuning_regs.sv */
// configuration and status register bank for hub port tuning
// Operation
// - gang pin select bits 5:0 choose the shared fault signal source
// - drive current trim bits 2:0 set high-speed output current step
// - squelch trim bits 2:0 set trip point; bits 7:3 read zero
// - upstream link status read-only: state 7:4, substate 2:0, bit 3 zero
// - port 1 has its own drive and squelch trims, same encoding
// - port 1 link status read-only, laid out like upstream
// - gang enable set: port fault taken from the selected shared signal
`timescale 1ns/100ps
`include "hub_port_tuning_regs.svh"
module hub_port_tuning_regs
	import hub_port_tuning_pkg::*;
(
	// clocking
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clockEnable,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [7:0] wb_dat_i,
	input wire logic wb_sel_i,
	output logic [7:0] wb_dat_o,
	output logic wb_ack_i_unused_guard,
	output logic wb_ack_o,
	// fault source pins
	input wire logic testResetPin,
	input wire logic [3:0] faultSenseIn,
	input wire logic romClockPin,
	input wire logic romDataPin,
	input wire logic [3:0] powerCtlPin,
	input wire logic mgmtBusClockPin,
	// link status from the superspeed cores
	input wire logic [3:0] upLinkState,
	input wire logic [2:0] upLinkSubState,
	input wire logic [3:0] port1LinkState,
	input wire logic [2:0] port1LinkSubState,
	// trim outputs to the phys
	output logic [2:0] upDriveCurrentTrim,
	output logic [2:0] upSquelchTripTrim,
	output logic [2:0] port1DriveCurrentTrim,
	output logic [2:0] port1SquelchTripTrim,
	// port 1 fault result
	input wire logic port1OwnFault,
	output logic port1Fault
);
	bus_state_t busState;
	reg_byte_t gangPinSelect;
	reg_byte_t gangEnable;
	reg_byte_t upHsDriveTrim;
	reg_byte_t upSquelchTrim;
	reg_byte_t port1HsDriveTrim;
	reg_byte_t port1SquelchTrim;
	logic [11:0] pinSync;
	logic sharedFault;

	// wb_ack_i_unused_guard is a spare error line, never asserted
	assign wb_ack_i_unused_guard = 1'b0;

	function automatic logic hit(input logic [15:0] adr, input logic [15:0] ofs);
		hit = (adr == ofs);
	endfunction

	wire request = wb_cyc_i && wb_stb_i && (busState == BUS_IDLE);
	wire writeStrobe = request && wb_we_i && wb_sel_i;
	wire hitGangSel = hit(wb_adr_i, `OFS_GANG_PIN_SELECT);
	wire hitGangEn = hit(wb_adr_i, `OFS_GANG_ENABLE);
	wire hitUpDrive = hit(wb_adr_i, `OFS_UP_HS_DRIVE_TRIM);
	wire hitUpSquelch = hit(wb_adr_i, `OFS_UP_SQUELCH_TRIM);
	wire hitUpStatus = hit(wb_adr_i, `OFS_UP_SS_STATUS);
	wire hitP1Drive = hit(wb_adr_i, `OFS_P1_HS_DRIVE_TRIM);
	wire hitP1Squelch = hit(wb_adr_i, `OFS_P1_SQUELCH_TRIM);
	wire hitP1Status = hit(wb_adr_i, `OFS_P1_SS_STATUS);

	// link status words, bit 3 reads zero
	wire [7:0] upStatusWord = {upLinkState, 1'b0, upLinkSubState};
	wire [7:0] p1StatusWord = {port1LinkState, 1'b0, port1LinkSubState};
	// squelch registers: reserved bits read zero
	wire [7:0] upSquelchWord = {5'h00, upSquelchTrim[`TRIM_MSB:0]};
	wire [7:0] p1SquelchWord = {5'h00, port1SquelchTrim[`TRIM_MSB:0]};

	// read select, unmapped addresses read zero
	wire [7:0] readMux =
		hitGangSel ? gangPinSelect :
		hitGangEn ? gangEnable :
		hitUpDrive ? upHsDriveTrim :
		hitUpSquelch ? upSquelchWord :
		hitUpStatus ? upStatusWord :
		hitP1Drive ? port1HsDriveTrim :
		hitP1Squelch ? p1SquelchWord :
		hitP1Status ? p1StatusWord :
		8'h00;

	// one-wait-state ack, dropped for one cycle after
	wire bus_state_t next_busState = request ? BUS_ACK : BUS_IDLE;

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			busState <= BUS_IDLE;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 8'h00;
		end
		else if (clockEnable)
		begin
			busState <= next_busState;
			wb_ack_o <= request;
			wb_dat_o <= request ? readMux : 8'h00;
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gangPinSelect <= `REG_RESET_VAL;
			gangEnable <= `REG_RESET_VAL;
			upHsDriveTrim <= `REG_RESET_VAL;
			upSquelchTrim <= `REG_RESET_VAL;
			port1HsDriveTrim <= `REG_RESET_VAL;
			port1SquelchTrim <= `REG_RESET_VAL;
		end
		else if (clockEnable && writeStrobe)
		begin
			if (hitGangSel)
				gangPinSelect <= wb_dat_i;
			if (hitGangEn)
				gangEnable <= wb_dat_i;
			if (hitUpDrive)
				upHsDriveTrim <= wb_dat_i;
			if (hitUpSquelch)
				upSquelchTrim <= wb_dat_i;
			if (hitP1Drive)
				port1HsDriveTrim <= wb_dat_i;
			if (hitP1Squelch)
				port1SquelchTrim <= wb_dat_i;
		end
	end

	// trim fields drive the phys directly
	assign upDriveCurrentTrim = upHsDriveTrim[`TRIM_MSB:0];
	assign upSquelchTripTrim = upSquelchTrim[`TRIM_MSB:0];
	assign port1DriveCurrentTrim = port1HsDriveTrim[`TRIM_MSB:0];
	assign port1SquelchTripTrim = port1SquelchTrim[`TRIM_MSB:0];

	pin_sync3 #(
		.WIDTH(12)
	) u_sync (
		.clock(clock),
		.rst_n(rst_n),
		.clockEnable(clockEnable),
		.asyncIn({mgmtBusClockPin, powerCtlPin, romDataPin, romClockPin, faultSenseIn,
			testResetPin}),
		.syncOut(pinSync)
	);

	// invalid codes select nothing (software keeps to the valid set)
	fault_source_mux u_mux (
		.sharedFaultSourceCode(gangPinSelect[`GANG_SEL_MSB:0]),
		.testResetPin(pinSync[0]),
		.faultSenseIn(pinSync[4:1]),
		.romClockPin(pinSync[5]),
		.romDataPin(pinSync[6]),
		.powerCtlPin(pinSync[10:7]),
		.mgmtBusClockPin(pinSync[11]),
		.sharedFault(sharedFault)
	);

	wire port1FaultShareEnable = gangEnable[`GANG_EN_P1_BIT];
	wire next_port1Fault = port1FaultShareEnable ? sharedFault : port1OwnFault;

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			port1Fault <= 1'b0;
		else if (clockEnable)
			port1Fault <= next_port1Fault;
	end
endmodule

/* hw/hub_port_tuning_regs.svh */
// register offsets, field positions and codes of the hub port tuning bank
`ifndef HUB_PORT_TUNING_REGS_SVH
`define HUB_PORT_TUNING_REGS_SVH

`define OFS_GANG_PIN_SELECT 16'h525b
`define OFS_UP_HS_DRIVE_TRIM 16'h60ca
`define OFS_UP_SQUELCH_TRIM 16'h60cc
`define OFS_UP_SS_STATUS 16'h61c0
`define OFS_P1_HS_DRIVE_TRIM 16'h64ca
`define OFS_P1_SQUELCH_TRIM 16'h64cc
`define OFS_P1_SS_STATUS 16'h65c0
`define OFS_GANG_ENABLE 16'h525a

`define GANG_SEL_MSB 5
`define TRIM_MSB 2
`define LINK_STATE_LSB 4
`define LINK_SUB_MSB 2
`define GANG_EN_P1_BIT 1
`define GANG_EN_MSB 4

`define REG_RESET_VAL 8'h00
`define SYNC_STAGES 3

`define SRC_TEST_RESET 6'h00
`define SRC_SENSE_1 6'h01
`define SRC_SENSE_2 6'h03
`define SRC_ROM_CLK 6'h04
`define SRC_ROM_DATA 6'h05
`define SRC_SENSE_3 6'h06
`define SRC_SENSE_4 6'h07
`define SRC_PWR_1 6'h08
`define SRC_PWR_2 6'h09
`define SRC_PWR_3 6'h0a
`define SRC_PWR_4 6'h0b
`define SRC_MGMT_CLK 6'h0f

`endif

/* hw/hub_port_tuning_pkg.sv */
// types shared by the hub port tuning bank
package hub_port_tuning_pkg;
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK = 2'b10
	} bus_state_t;
	typedef logic [7:0] reg_byte_t;
	typedef logic [2:0] trim_t;
endpackage

/* hw/pin_sync3.sv */
// three-stage synchroniser with agreement of the last two stages
`timescale 1ns/100ps
module pin_sync3
	import hub_port_tuning_pkg::*;
#(
	parameter int WIDTH = 12
)
(
	// clocking
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clockEnable,
	// data
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	wire [WIDTH-1:0] agreeMask = ~(stage2 ^ stage3);
	wire [WIDTH-1:0] next_syncOut = (stage3 & agreeMask) | (syncOut & ~agreeMask);

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
			syncOut <= '0;
		end
		else if (clockEnable)
		begin
			stage1 <= asyncIn;
			stage2 <= stage1;
			stage3 <= stage2;
			syncOut <= next_syncOut;
		end
	end
endmodule

/* hw/fault_source_mux.sv */
// picks the shared fault signal by its source code
`timescale 1ns/100ps
`include "hub_port_tuning_regs.svh"
module fault_source_mux
	import hub_port_tuning_pkg::*;
(
	// selection
	input wire logic [5:0] sharedFaultSourceCode,
	// candidate signals, already synchronised
	input wire logic testResetPin,
	input wire logic [3:0] faultSenseIn,
	input wire logic romClockPin,
	input wire logic romDataPin,
	input wire logic [3:0] powerCtlPin,
	input wire logic mgmtBusClockPin,
	// result
	output logic sharedFault
);
	// codes outside the valid set yield zero
	always_comb
	begin
		case (sharedFaultSourceCode)
			`SRC_TEST_RESET: sharedFault = testResetPin;
			`SRC_SENSE_1: sharedFault = faultSenseIn[0];
			`SRC_SENSE_2: sharedFault = faultSenseIn[1];
			`SRC_ROM_CLK: sharedFault = romClockPin;
			`SRC_ROM_DATA: sharedFault = romDataPin;
			`SRC_SENSE_3: sharedFault = faultSenseIn[2];
			`SRC_SENSE_4: sharedFault = faultSenseIn[3];
			`SRC_PWR_1: sharedFault = powerCtlPin[0];
			`SRC_PWR_2: sharedFault = powerCtlPin[1];
			`SRC_PWR_3: sharedFault = powerCtlPin[2];
			`SRC_PWR_4: sharedFault = powerCtlPin[3];
			`SRC_MGMT_CLK: sharedFault = mgmtBusClockPin;
			default: sharedFault = 1'b0;
		endcase
	end
endmodule

/* dv/hub_port_tuning_regs_properties.sv */
// assertions on the hub port tuning register bank
`timescale 1ns/100ps
module hub_port_tuning_regs_properties (
	// clocking and bus
	input wire logic clock,
	input wire logic rst_n,
	input wire logic wb_we_i,
	input wire logic wb_sel_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [7:0] wb_dat_i,
	input wire logic [7:0] wb_dat_o,
	input wire logic wb_ack_o,
	// status and trims
	input wire logic [3:0] upLinkState,
	input wire logic [2:0] upLinkSubState,
	input wire logic [3:0] port1LinkState,
	input wire logic [2:0] port1LinkSubState,
	input wire logic [2:0] upDriveCurrentTrim,
	input wire logic [2:0] upSquelchTripTrim,
	input wire logic [2:0] port1DriveCurrentTrim,
	input wire logic [2:0] port1SquelchTripTrim
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence s_wr(logic [15:0] a); wb_ack_o && wb_we_i && wb_sel_i && wb_adr_i == a; endsequence
	sequence s_rd(logic [15:0] a); wb_ack_o && !wb_we_i && wb_adr_i == a; endsequence
	property p_ack; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack longer than one cycle");
	property p_up_st; s_rd(16'h61c0) |-> wb_dat_o == {$past(upLinkState), 1'b0, $past(upLinkSubState)}; endproperty
	a_up_st: assert property (p_up_st) else $error("upstream status read wrong");
	property p_p1_st; s_rd(16'h65c0) |-> wb_dat_o == {$past(port1LinkState), 1'b0, $past(port1LinkSubState)}; endproperty
	a_p1_st: assert property (p_p1_st) else $error("port 1 status read wrong");
	property p_sq_rsv; (s_rd(16'h60cc) or s_rd(16'h64cc)) |-> wb_dat_o[7:3] == 5'h00; endproperty
	a_sq_rsv: assert property (p_sq_rsv) else $error("squelch upper bits not zero");
	property p_up_drv; s_wr(16'h60ca) |-> upDriveCurrentTrim == wb_dat_i[2:0]; endproperty
	a_up_drv: assert property (p_up_drv) else $error("upstream drive trim wrong");
	property p_up_sq; s_wr(16'h60cc) |-> upSquelchTripTrim == wb_dat_i[2:0]; endproperty
	a_up_sq: assert property (p_up_sq) else $error("upstream squelch trim wrong");
	property p_p1_drv; s_wr(16'h64ca) |-> port1DriveCurrentTrim == wb_dat_i[2:0]; endproperty
	a_p1_drv: assert property (p_p1_drv) else $error("port 1 drive trim wrong");
	property p_p1_sq; s_wr(16'h64cc) |-> port1SquelchTripTrim == wb_dat_i[2:0]; endproperty
	a_p1_sq: assert property (p_p1_sq) else $error("port 1 squelch trim wrong");
endmodule
bind hub_port_tuning_regs hub_port_tuning_regs_properties u_props (.*);

/* dv/hub_port_tuning_regs_tb.sv */
// self-checking bench for the hub port tuning register bank
`timescale 1ns/100ps
module hub_port_tuning_regs_tb;
	logic clock = 0;
	logic rst_n = 0;
	logic cyc = 0;
	logic we = 0;
	logic [15:0] adr = 16'h0000;
	logic [7:0] dat = 8'h00;
	logic [15:0] src = 16'h0000;
	logic own = 0;
	logic ce = 1;
	logic [3:0] upSt = 4'h0;
	logic [2:0] upSub = 3'h0;
	logic [3:0] p1St = 4'h0;
	logic [2:0] p1Sub = 3'h0;
	logic [7:0] q;
	logic [7:0] rdat;
	logic ack;
	logic fault;
	logic [2:0] upDrv, upSq, p1Drv, p1Sq;
	int fails = 0;
	int cmp_count = 0;
	logic [15:0] offs [8] = '{16'h525a, 16'h525b, 16'h60ca, 16'h60cc, 16'h61c0, 16'h64ca,
		16'h64cc, 16'h65c0};
	// only the valid shared fault source codes are ever written
	logic [5:0] codes [12] = '{6'h00, 6'h01, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08,
		6'h09, 6'h0a, 6'h0b, 6'h0f};
	hub_port_tuning_regs u_dut (
		.clock(clock), .rst_n(rst_n), .clockEnable(ce),
		.wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat),
		.wb_sel_i(1'b1), .wb_dat_o(rdat), .wb_ack_i_unused_guard(), .wb_ack_o(ack),
		.testResetPin(src[0]), .faultSenseIn({src[7], src[6], src[3], src[1]}),
		.romClockPin(src[4]), .romDataPin(src[5]), .powerCtlPin(src[11:8]),
		.mgmtBusClockPin(src[15]), .upLinkState(upSt), .upLinkSubState(upSub),
		.port1LinkState(p1St), .port1LinkSubState(p1Sub), .upDriveCurrentTrim(upDrv),
		.upSquelchTripTrim(upSq), .port1DriveCurrentTrim(p1Drv),
		.port1SquelchTripTrim(p1Sq), .port1OwnFault(own), .port1Fault(fault)
	);
	initial
	begin
		forever #5 clock = ~clock;
	end
	task automatic results();
		if (fails == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e)
		begin
			fails++;
			$display("[FAIL] %0t %h %h", $time, s, e);
		end
	endtask
	task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clock);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		q = rdat;
		cyc <= 1'b0;
		if (n >= 20)
		begin
			fails++;
			results();
		end
	endtask
	task automatic s_reset();
		foreach (offs[i])
		begin
			bus(0, offs[i], 8'h00);
			chk(q, 8'h00);
		end
	endtask
	task automatic s_trims();
		logic [2:0] t;
		for (int i = 0; i < 8; i++)
		begin
			t = 3'(i);
			bus(1, 16'h60ca, {5'h1b, t});
			bus(1, 16'h60cc, {5'h1f, ~t});
			bus(1, 16'h64ca, {5'h04, t ^ 3'h5});
			bus(1, 16'h64cc, {5'h1f, t ^ 3'h3});
			chk({2'b00, upDrv, upSq}, {2'b00, t, ~t});
			chk({2'b00, p1Drv, p1Sq}, {2'b00, t ^ 3'h5, t ^ 3'h3});
			bus(0, 16'h60ca, 8'h00);
			chk(q, {5'h1b, t});
			bus(0, 16'h60cc, 8'h00);
			chk(q, {5'h00, ~t});
			bus(0, 16'h64ca, 8'h00);
			chk(q, {5'h04, t ^ 3'h5});
			bus(0, 16'h64cc, 8'h00);
			chk(q, {5'h00, t ^ 3'h3});
		end
	endtask
	task automatic s_status();
		upSt <= 4'ha;
		upSub <= 3'h5;
		p1St <= 4'h3;
		p1Sub <= 3'h6;
		bus(1, 16'h61c0, 8'hff);
		bus(1, 16'h65c0, 8'hff);
		bus(0, 16'h61c0, 8'h00);
		chk(q, 8'ha5);
		bus(0, 16'h65c0, 8'h00);
		chk(q, 8'h36);
		bus(0, 16'h1234, 8'h00);
		chk(q, 8'h00);
	endtask
	task automatic s_gang();
		bus(1, 16'h525a, 8'h02);
		foreach (codes[i])
		begin
			bus(1, 16'h525b, {2'b00, codes[i]});
			bus(0, 16'h525b, 8'h00);
			chk(q, {2'b00, codes[i]});
			src <= 16'hffff ^ (16'h0001 << codes[i]);
			own <= 1'b1;
			repeat (8) @(posedge clock);
			chk({7'h00, fault}, 8'h00);
			src <= 16'h0001 << codes[i];
			own <= 1'b0;
			repeat (8) @(posedge clock);
			chk({7'h00, fault}, 8'h01);
		end
		bus(1, 16'h525a, 8'h00);
		repeat (8) @(posedge clock);
		chk({7'h00, fault}, 8'h00);
		own <= 1'b1;
		src <= 16'h0000;
		repeat (8) @(posedge clock);
		chk({7'h00, fault}, 8'h01);
		// clock enable low freezes the fault output
		ce <= 1'b0;
		own <= 1'b0;
		repeat (4) @(posedge clock);
		chk({7'h00, fault}, 8'h01);
		ce <= 1'b1;
		repeat (4) @(posedge clock);
		chk({7'h00, fault}, 8'h00);
	endtask
	initial
	begin
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		s_reset();
		s_trims();
		s_status();
		s_gang();
		results();
	end
endmodule
